// *** xsl_slot.sv ***
// Purpose: Slot-side control of an expansion card on the 32-bit async bus
// Assumes: Pins pass two flip-flops; user side is on clk_in
// Notes:   Summary of operation follows
// Summary of operation
// R1: Assert slot response quickly on own address
// R2: Controller flags collisions with bus error
// R3: Release slot response during quick interrupt cycles
// R4: Unconfigured, chain-in low: answer configuration space
// R5: Chain-out negated until configured or silenced
// R6: Backplane forwards chain across empty slots
// R7: Sense low means legacy backplane
// R8: Legacy backplane unsupported: disable, pass chain through
// R9: Never drive the bus-ownership line
// R10: Toggle bus request to register, unregister
// R11: Controller grants one card, one cycle
// R12: Never drive the grant-acknowledge line
// R13: Bus-want shows only legacy requests pending
// R14: Read-enable valid whole cycle, high reads
// R15: Read-enable set before the cycle strobe
// R16: Latch high address at full strobe fall
// R17: Short low address used without latching
// R18: Memory-space code valid whole cycle
// R19: Decode memory-space code; reserved gets nothing
// R20: Low configuration cycles run legacy style
// R21: Configuration: cache inhibit, no multi-transfer ack
// R22: Compat strobe without full strobe is legacy
// R23: Buffered reset clears configuration logic
// R24: Bus error tri-states bus outputs
// R25: Full strobe starts every native cycle
`default_nettype none
module xsl_slot #(
   parameter bit          LEGACY_OK  = 1'b0,
   parameter bit          QUICK_INT  = 1'b0,
   parameter int          MEM_BITS   = 8
) (
   input  wire logic                 clk_in,
   input  wire logic                 reset_in,
   input  wire xsl_pkg::xsl_addr_t   addr_in,
   input  wire xsl_pkg::xsl_ctl_t    ctl_in,
   input  wire logic [MEM_BITS-1:0]  mem_base_in,
   input  wire logic                 cfg_done_in,
   input  wire logic                 cfg_shutup_in,
   input  wire logic                 master_on_in,
   output logic                      slot_response_n_out,
   output logic                      slot_response_oe_n_out,
   output logic                      bus_oe_n_out,
   output logic                      cache_inhibit_n_out,
   output logic                      multi_transfer_ack_n_out,
   output logic                      chain_enable_out_n_out,
   output logic                      slot_bus_request_n_out,
   output logic                      bus_granted_out,
   output logic                      legacy_want_out,
   output logic                      configured_out,
   output logic                      config_cycle_out,
   output logic                      legacy_cycle_out,
   output xsl_pkg::xsl_addr_t        cycle_addr_out
);
   localparam xsl_pkg::xsl_ctl_t CTL_INIT = '{
      fcs_n: 1'b1, ccs_n: 1'b1, short_cycle_strobe_n_n: 1'b1, bus_error_n_n: 1'b1, buffered_io_reset_n_n: 1'b1,
      cfgin_n: 1'b1, sense: 1'b1, bgn_n: 1'b1, legacy_bus_want_n_n: 1'b1};

   xsl_pkg::xsl_addr_t s_addr;
   xsl_pkg::xsl_ctl_t  s_ctl;
   xsl_pkg::xsl_cyc_t  cyc_r;
   logic               fcs_d_r;
   logic               conf_r;
   logic               reg_r;
   logic               bus_error_n_c;
   logic               fcs_fall;
   logic               disabled;
   logic               hit_cfg;
   logic               hit_mem;
   logic               cpu_cyc;

   // ======================================================
   // Pin synchronisers
   xsl_sync #(.W($bits(xsl_pkg::xsl_addr_t)), .INIT('0)) u_sync_addr (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .d_in     (addr_in),
      .q_out    (s_addr)
   );
   xsl_sync #(.W($bits(xsl_pkg::xsl_ctl_t)), .INIT(CTL_INIT)) u_sync_ctl (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .d_in     (ctl_in),
      .q_out    (s_ctl)
   );

   // ======================================================
   // Decode helpers
   function automatic xsl_pkg::xsl_kind_t space_kind(input logic [2:0] code);
      if (code == xsl_pkg::SPACE_UDATA || code == xsl_pkg::SPACE_UPROG ||
          code == xsl_pkg::SPACE_SDATA || code == xsl_pkg::SPACE_SPROG) begin
         space_kind = xsl_pkg::KIND_MEM; // R19
      end else if (code == xsl_pkg::SPACE_CPU) begin
         space_kind = xsl_pkg::KIND_CPU; // R19
      end else begin
         space_kind = xsl_pkg::KIND_NONE; // R19
      end
   endfunction

   // Address and strobe travel through equal sync depth, so address aligns with the edge
   assign fcs_fall = !s_ctl.fcs_n && fcs_d_r; // R25
   assign bus_error_n_c   = !s_ctl.bus_error_n_n;
   // Pulled-up sense: grounded only by a legacy backplane
   assign disabled = !s_ctl.sense && !LEGACY_OK; // R7 R8
   assign cpu_cyc  = space_kind(s_addr.space) == xsl_pkg::KIND_CPU;
   assign hit_cfg  = !conf_r && !s_ctl.cfgin_n && !disabled &&
                     space_kind(s_addr.space) == xsl_pkg::KIND_MEM &&
                     (s_addr.high_addr[31:16] == xsl_pkg::CFG_BASE_LOW ||
                      s_addr.high_addr[31:16] == xsl_pkg::CFG_BASE_HIGH); // R4 R20
   assign hit_mem  = conf_r && !disabled &&
                     space_kind(s_addr.space) == xsl_pkg::KIND_MEM &&
                     s_addr.high_addr[31 -: MEM_BITS] == mem_base_in; // R19

   // ======================================================
   // Cycle tracking
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         fcs_d_r <= xsl_pkg::RST_NEGATED;
      end else begin
         fcs_d_r <= s_ctl.fcs_n;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cyc_r            <= xsl_pkg::CYC_IDLE;
         config_cycle_out <= 1'b0;
         cycle_addr_out   <= '0;
      end else begin
         case (cyc_r)
            xsl_pkg::CYC_IDLE: begin
               if (fcs_fall) begin
                  cycle_addr_out   <= s_addr; // R16
                  config_cycle_out <= hit_cfg;
                  cyc_r <= (hit_cfg || hit_mem) ? xsl_pkg::CYC_SLAVE
                                                : xsl_pkg::CYC_OTHER; // R1
               end else if (!s_ctl.ccs_n && s_ctl.fcs_n) begin
                  cyc_r <= xsl_pkg::CYC_LEGACY; // R22
               end
            end
            xsl_pkg::CYC_SLAVE, xsl_pkg::CYC_OTHER: begin
               // Low address and read are held by the master, so track them live
               cycle_addr_out.low_addr <= s_addr.low_addr; // R17
               cycle_addr_out.read     <= s_addr.read;
               if (s_ctl.fcs_n) begin
                  cyc_r            <= xsl_pkg::CYC_IDLE;
                  config_cycle_out <= 1'b0;
               end
            end
            xsl_pkg::CYC_LEGACY: begin
               if (s_ctl.ccs_n) begin
                  cyc_r <= xsl_pkg::CYC_IDLE;
               end
            end
            default: cyc_r <= xsl_pkg::CYC_IDLE;
         endcase
      end
   end

   // ======================================================
   // Slave response and bus outputs
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         slot_response_n_out      <= xsl_pkg::RST_NEGATED;
         slot_response_oe_n_out   <= xsl_pkg::RST_NEGATED;
         bus_oe_n_out             <= xsl_pkg::RST_NEGATED;
         cache_inhibit_n_out      <= xsl_pkg::RST_NEGATED;
         legacy_cycle_out         <= 1'b0;
      end else begin
         slot_response_n_out    <= !(fcs_fall && (hit_cfg || hit_mem)) &&
                                   !(cyc_r == xsl_pkg::CYC_SLAVE && !s_ctl.fcs_n); // R1
         // Quick interrupt cards let the controller own the line in CPU space
         slot_response_oe_n_out <= bus_error_n_c || (QUICK_INT && cpu_cyc) || disabled; // R3 R24
         bus_oe_n_out           <= bus_error_n_c || cyc_r != xsl_pkg::CYC_SLAVE; // R24
         // Card is not cacheable, so inhibit rides with every response
         cache_inhibit_n_out    <= !(cyc_r == xsl_pkg::CYC_SLAVE); // R21
         legacy_cycle_out       <= cyc_r == xsl_pkg::CYC_LEGACY; // R22
      end
   end

   // No multi-transfer support keeps config cycles legacy-shaped
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         multi_transfer_ack_n_out <= xsl_pkg::RST_NEGATED;
      end else begin
         multi_transfer_ack_n_out <= xsl_pkg::RST_NEGATED; // R21
      end
   end

   // ======================================================
   // Configuration chain
   always_ff @(posedge clk_in) begin
      if (reset_in || !s_ctl.buffered_io_reset_n_n) begin
         conf_r <= 1'b0; // R23
      end else if (config_cycle_out && (cfg_done_in || cfg_shutup_in)) begin
         conf_r <= 1'b1; // R5
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in || !s_ctl.buffered_io_reset_n_n) begin
         chain_enable_out_n_out <= xsl_pkg::RST_NEGATED; // R5 R23
      end else if (disabled) begin
         chain_enable_out_n_out <= s_ctl.cfgin_n; // R8
      end else begin
         chain_enable_out_n_out <= !conf_r; // R5
      end
      if (reset_in) begin
         configured_out <= 1'b0;
      end else begin
         configured_out <= conf_r;
      end
   end

   // ======================================================
   // Mastering: ownership and grant-ack lines have no driver here  // R9 R12
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         reg_r                  <= 1'b0;
         slot_bus_request_n_out <= xsl_pkg::RST_NEGATED;
         bus_granted_out        <= 1'b0;
         legacy_want_out        <= 1'b0;
      end else begin
         if (master_on_in != reg_r && !disabled) begin
            reg_r                  <= master_on_in;
            slot_bus_request_n_out <= !slot_bus_request_n_out; // R10
         end
         bus_granted_out <= reg_r && !s_ctl.bgn_n; // R11
         legacy_want_out <= !s_ctl.legacy_bus_want_n_n; // R13
      end
   end

   // ======================================================
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   AST_RESP_ON_HIT: assert property (fcs_fall && hit_cfg |=> !slot_response_n_out) // R1
      else $error("no response to config hit");
   AST_QUICK_RELEASE: assert property (QUICK_INT && cpu_cyc |=> slot_response_oe_n_out) // R3
      else $error("response driven in cpu space");
   AST_RESP_DRIVEN: assert property ( // R3
      !bus_error_n_c && !disabled && !(QUICK_INT && cpu_cyc) |=> !slot_response_oe_n_out)
      else $error("response line not driven");
   AST_CFG_HIT: assert property (fcs_fall && !conf_r && !s_ctl.cfgin_n && !disabled && // R4
      s_addr.space == xsl_pkg::SPACE_UDATA &&
      s_addr.high_addr[31:16] == xsl_pkg::CFG_BASE_HIGH |=> cyc_r == xsl_pkg::CYC_SLAVE)
      else $error("config space missed");
   AST_CHAIN_HELD: assert property ( // R5
      !conf_r && !disabled ##1 !conf_r && !disabled |-> chain_enable_out_n_out)
      else $error("chain out early");
   AST_PASS_THRU: assert property ( // R8
      disabled && s_ctl.buffered_io_reset_n_n |=> chain_enable_out_n_out == $past(s_ctl.cfgin_n))
      else $error("chain not passed");
   AST_REQ_TOGGLE: assert property ( // R10
      master_on_in != reg_r && !disabled |=>
      slot_bus_request_n_out != $past(slot_bus_request_n_out))
      else $error("request not toggled");
   AST_LATCH: assert property ( // R16
      cyc_r == xsl_pkg::CYC_IDLE && fcs_fall |=>
      cycle_addr_out.high_addr == $past(s_addr.high_addr))
      else $error("address not latched");
   AST_RESERVED: assert property ( // R19
      fcs_fall && space_kind(s_addr.space) == xsl_pkg::KIND_NONE |=> slot_response_n_out [*2])
      else $error("response to reserved space");
   AST_MULTI_TRANSFER_ACK_N: assert property (multi_transfer_ack_n_out) // R21
      else $error("multi ack asserted");
   AST_LEGACY: assert property ( // R22
      cyc_r == xsl_pkg::CYC_IDLE && !s_ctl.ccs_n && s_ctl.fcs_n |=>
      ##1 legacy_cycle_out && slot_response_n_out)
      else $error("legacy cycle not seen");
   AST_BUFFERED_IO_RESET_N: assert property (!s_ctl.buffered_io_reset_n_n |=> !conf_r && chain_enable_out_n_out) // R23
      else $error("io reset ignored");
   AST_BUS_ERROR_N: assert property (bus_error_n_c |=> bus_oe_n_out && slot_response_oe_n_out) // R24
      else $error("outputs driven in bus error");

   COV_CFG: cover property (fcs_fall && hit_cfg ##[1:4] cfg_done_in);
   COV_MEM: cover property (fcs_fall && hit_mem);
   COV_LEG: cover property (cyc_r == xsl_pkg::CYC_LEGACY);
   COV_GNT: cover property (bus_granted_out);
endmodule
`default_nettype wire

// *** xsl_pkg.sv ***
// Purpose: Shared constants and types for the expansion slot interface
// Assumes: One 10 MHz clock, synchronous active-high reset
// Notes:   All pin-side values are active low unless named otherwise
`default_nettype none
package xsl_pkg;
   // ======================================================
   // Configuration space
   localparam logic [15:0] CFG_BASE_LOW  = 16'h00e8;
   localparam logic [15:0] CFG_BASE_HIGH = 16'hff00;
   localparam int          PULLUP_OHMS   = 1000;
   // ======================================================
   // Reset values
   localparam logic        RST_NEGATED   = 1'b1;
   localparam logic        RST_RELEASED  = 1'b1;
   localparam logic [2:0]  SPACE_NONE    = 3'h0;
   // ======================================================
   // Memory space codes
   localparam logic [2:0]  SPACE_UDATA   = 3'h1;
   localparam logic [2:0]  SPACE_UPROG   = 3'h2;
   localparam logic [2:0]  SPACE_SDATA   = 3'h5;
   localparam logic [2:0]  SPACE_SPROG   = 3'h6;
   localparam logic [2:0]  SPACE_CPU     = 3'h7;

   typedef enum logic [1:0] {
      KIND_NONE,
      KIND_MEM,
      KIND_CPU
   } xsl_kind_t;

   typedef enum logic [1:0] {
      CYC_IDLE,
      CYC_SLAVE,
      CYC_OTHER,
      CYC_LEGACY
   } xsl_cyc_t;

   // Address-phase bundle as seen on the pins
   typedef struct packed {
      logic [31:8] high_addr;
      logic [7:2]  low_addr;
      logic [2:0]  space;
      logic        read;
   } xsl_addr_t;

   // Strobe and control inputs bundle
   typedef struct packed {
      logic fcs_n;
      logic ccs_n;
      logic short_cycle_strobe_n_n;
      logic bus_error_n_n;
      logic buffered_io_reset_n_n;
      logic cfgin_n;
      logic sense;
      logic bgn_n;
      logic legacy_bus_want_n_n;
   } xsl_ctl_t;
endpackage
`default_nettype wire

// *** xsl_sync.sv ***
// Purpose: Two-stage synchroniser for a group of pin inputs
// Assumes: Inputs asynchronous to clk_in
// Notes:   First stage feeds only the second stage
`default_nettype none
module xsl_sync #(
   parameter int          W        = 1,
   parameter logic [W-1:0] INIT    = '0
) (
   input  wire logic         clk_in,
   input  wire logic         reset_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         meta_r <= INIT;
         q_out  <= INIT;
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end
endmodule
`default_nettype wire

// *** xsl_ctrl_model.sv ***
// Purpose: Behavioural bus controller facing one expansion slot
// Assumes: Bench commands each cycle through go_in and cyc_in
// Notes:   Released address pins toggle so a stale value never passes
`default_nettype none
module xsl_ctrl_model (
   input  wire logic               clk_in,
   input  wire logic               reset_in,
   input  wire logic               go_in,
   input  wire logic               compat_in,
   input  wire xsl_pkg::xsl_addr_t cyc_in,
   input  wire logic [3:0]         lines_in,
   input  wire logic               legacy_bus_want_n_n_in,
   input  wire logic               bus_req_n_in,
   output xsl_pkg::xsl_addr_t      addr_out,
   output xsl_pkg::xsl_ctl_t       ctl_out
);
   logic       ph_r;
   logic       fcs_r;
   logic       ccs_r;
   logic       bgn_r;
   logic       reg_r;
   logic       req_r;
   logic [2:0] gcnt_r;
   // ======================================================
   // Address phase and strobes
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ph_r     <= 1'b0;
         fcs_r    <= 1'b1;
         ccs_r    <= 1'b1;
         addr_out <= '0;
      end else if (!go_in) begin
         ph_r     <= 1'b0;
         fcs_r    <= 1'b1;
         ccs_r    <= 1'b1;
         addr_out <= ~addr_out;
      end else if (!ph_r && fcs_r && ccs_r) begin
         addr_out <= cyc_in;
         ph_r     <= 1'b1;
      end else if (ph_r) begin
         fcs_r <= compat_in;
         ccs_r <= 1'b0;
         ph_r  <= 1'b0;
      end else begin
         // Upper lines let go one clock after the strobe: no longer hold
         addr_out.high_addr <= ~addr_out.high_addr;
      end
   end
   // ======================================================
   // Registration and grants
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         req_r  <= 1'b1;
         reg_r  <= 1'b0;
         gcnt_r <= 3'h0;
         bgn_r  <= 1'b1;
      end else begin
         req_r  <= bus_req_n_in;
         gcnt_r <= gcnt_r + 3'h1;
         if (req_r != bus_req_n_in) begin
            reg_r <= !reg_r;
         end
         bgn_r <= !(reg_r && gcnt_r == 3'h0);
      end
   end
   always_comb begin
      ctl_out = '{fcs_n: fcs_r, ccs_n: ccs_r, short_cycle_strobe_n_n: 1'b1, bus_error_n_n: lines_in[3],
                  buffered_io_reset_n_n: lines_in[2], cfgin_n: lines_in[1], sense: lines_in[0],
                  bgn_n: bgn_r, legacy_bus_want_n_n: legacy_bus_want_n_n_in};
   end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Purpose: Self-checking bench for the expansion slot control block
// Assumes: Controller model drives every bus pin of the slot
// Notes:   Addresses and some space codes come from a fixed-seed shift register
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // ======================================================
   // Signals
   logic               clk_in   = 1'b0;
   logic               reset_in = 1'b1;
   logic               go_r     = 1'b0;
   logic               cmp_r    = 1'b0;
   logic               legacy_bus_want_n_n_r = 1'b1;
   logic [3:0]         lines_r  = 4'hf;
   logic [7:0]         base_r   = 8'h00;
   logic               done_r   = 1'b0;
   logic               shut_r   = 1'b0;
   logic               mon_r    = 1'b0;
   logic               exp_conf = 1'b0;
   logic               seen     = 1'b0;
   logic [31:0]        seed     = 32'hd1d57d91;
   xsl_pkg::xsl_addr_t cyc_r    = '0;
   xsl_pkg::xsl_addr_t addr_w, cad_w;
   xsl_pkg::xsl_ctl_t  ctl_w;
   logic               resp_n, resp_oe_n, boe_n, cache_inhibit_n_n, multi_transfer_ack_n_n, chain_n;
   logic               breq_n, gnt, want, conf, ccyc, lcyc;
   int                 err_count = 0;
   int                 cmp_count = 0;
   int                 k;
   always #50 clk_in = ~clk_in;
   xsl_ctrl_model u_ctrl (.clk_in(clk_in), .reset_in(reset_in), .go_in(go_r),
      .compat_in(cmp_r), .cyc_in(cyc_r), .lines_in(lines_r), .legacy_bus_want_n_n_in(legacy_bus_want_n_n_r),
      .bus_req_n_in(breq_n), .addr_out(addr_w), .ctl_out(ctl_w));
   xsl_slot u_dut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_w), .ctl_in(ctl_w),
      .mem_base_in(base_r), .cfg_done_in(done_r), .cfg_shutup_in(shut_r),
      .master_on_in(mon_r), .slot_response_n_out(resp_n), .slot_response_oe_n_out(resp_oe_n),
      .bus_oe_n_out(boe_n), .cache_inhibit_n_out(cache_inhibit_n_n), .multi_transfer_ack_n_out(multi_transfer_ack_n_n),
      .chain_enable_out_n_out(chain_n), .slot_bus_request_n_out(breq_n),
      .bus_granted_out(gnt), .legacy_want_out(want), .configured_out(conf),
      .config_cycle_out(ccyc), .legacy_cycle_out(lcyc), .cycle_addr_out(cad_w));
   // ======================================================
   // Checking helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic exp_hit(input logic [31:0] a, input logic [2:0] sp,
                                    input logic cm);
      if (cm || !(sp inside {3'h1, 3'h2, 3'h5, 3'h6}) || !lines_r[0]) return 1'b0;
      if (exp_conf) return a[31:24] == base_r;
      return !lines_r[1] && (a[31:16] == xsl_pkg::CFG_BASE_LOW ||
                             a[31:16] == xsl_pkg::CFG_BASE_HIGH);
   endfunction
   task automatic chk_bit(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_addr(input string what, input logic [23:0] exp, input logic [23:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // One bus cycle; act 1 configures, 2 silences, 3 raises bus error mid-cycle
   task automatic do_cycle(input logic [31:0] a, input logic [2:0] sp, input logic cm,
                           input int act);
      logic hit;
      @(posedge clk_in);
      // Judged after the edge so a base or pin change from the last edge is seen
      hit = exp_hit(a, sp, cm);
      cyc_r <= '{high_addr: a[31:8], low_addr: a[7:2], space: sp, read: a[0]};
      cmp_r <= cm;
      go_r  <= 1'b1;
      repeat (8) @(negedge clk_in);
      chk_bit("response", !hit, resp_n);
      chk_bit("legacy_cycle", cm, lcyc);
      if (hit) begin
         chk_bit("response_drive", 1'b0, resp_oe_n);
         chk_bit("cache_inhibit", 1'b0, cache_inhibit_n_n);
         chk_bit("config_cycle", !exp_conf, ccyc);
         chk_addr("high_addr", a[31:8], cad_w.high_addr);
         chk_addr("low_addr", {18'h0, a[7:2]}, {18'h0, cad_w.low_addr});
         chk_bit("read", a[0], cad_w.read);
      end
      if (act == 1 || act == 2) begin
         @(posedge clk_in);
         done_r <= (act == 1);
         shut_r <= (act == 2);
         @(posedge clk_in);
         done_r <= 1'b0;
         shut_r <= 1'b0;
         exp_conf = 1'b1;
         repeat (3) @(negedge clk_in);
         chk_bit("configured", 1'b1, conf);
         chk_bit("chain_out", 1'b0, chain_n);
      end
      if (act == 3) begin
         @(posedge clk_in);
         lines_r[3] <= 1'b0;
         repeat (4) @(negedge clk_in);
         chk_bit("bus_oe_bus_error_n", 1'b1, boe_n);
         @(posedge clk_in);
         lines_r[3] <= 1'b1;
         repeat (4) @(negedge clk_in);
         chk_bit("bus_oe_resume", 1'b0, boe_n);
      end
      @(posedge clk_in);
      go_r <= 1'b0;
      repeat (5) @(negedge clk_in);
      chk_bit("response_end", 1'b1, resp_n);
   endtask
   // ======================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_in);
      reset_in <= 1'b0;
      repeat (3) @(negedge clk_in);
      chk_bit("chain_reset", 1'b1, chain_n);
      chk_bit("multi_transfer_ack_n", 1'b1, multi_transfer_ack_n_n);
      @(posedge clk_in);
      lines_r[1] <= 1'b0;
      for (k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         do_cycle({16'hff00, seed[15:0]}, k[2:0], 1'b0, 0);
      end
      do_cycle({16'h00e8, seed[31:16]}, 3'h1, 1'b1, 0);
      do_cycle({16'h00e8, seed[15:0]}, 3'h5, 1'b0, 3);
      for (k = 0; k < 10; k++) begin
         seed = lfsr(seed);
         do_cycle(seed[0] ? {16'hff00, seed[31:16]} : seed, seed[4:2], 1'b0, 0);
      end
      $display("test configuration space done");
      do_cycle({16'hff00, seed[15:0]}, 3'h2, 1'b0, 1);
      @(posedge clk_in);
      base_r <= {2'b01, seed[5:0]};
      for (k = 0; k < 6; k++) begin
         seed = lfsr(seed);
         do_cycle({k[0] ? base_r : seed[31:24], seed[23:0]}, 3'h6, 1'b0, 0);
      end
      @(posedge clk_in);
      lines_r[2] <= 1'b0;
      repeat (4) @(posedge clk_in);
      lines_r[2] <= 1'b1;
      exp_conf = 1'b0;
      repeat (2) @(negedge clk_in);
      chk_bit("configured_buffered_io_reset_n", 1'b0, conf);
      chk_bit("chain_buffered_io_reset_n", 1'b1, chain_n);
      do_cycle({16'hff00, seed[15:0]}, 3'h6, 1'b0, 2);
      $display("test configure done");
      @(posedge clk_in);
      lines_r[0] <= 1'b0;
      lines_r[1] <= 1'b1;
      repeat (4) @(negedge clk_in);
      chk_bit("chain_pass_hi", 1'b1, chain_n);
      @(posedge clk_in);
      lines_r[1] <= 1'b0;
      repeat (4) @(negedge clk_in);
      chk_bit("chain_pass_lo", 1'b0, chain_n);
      do_cycle({base_r, seed[23:0]}, 3'h1, 1'b0, 0);
      @(posedge clk_in);
      lines_r[0] <= 1'b1;
      mon_r      <= 1'b1;
      legacy_bus_want_n_n_r   <= 1'b0;
      // Sense and bus-want each pass two flip-flops before the card acts
      repeat (4) @(negedge clk_in);
      chk_bit("request_on", 1'b0, breq_n);
      chk_bit("legacy_want", 1'b1, want);
      repeat (20) @(negedge clk_in) if (gnt === 1'b1) seen = 1'b1;
      chk_bit("granted", 1'b1, seen);
      @(posedge clk_in);
      mon_r <= 1'b0;
      repeat (3) @(negedge clk_in);
      chk_bit("request_off", 1'b1, breq_n);
      $display("test backplane and master done");
      results();
   end
   // Whole run is near 450 cycles; ample margin before giving up
   initial begin
      repeat (20000) @(posedge clk_in);
      err_count++;
      results();
   end
endmodule
`default_nettype wire
